// file: rtl/lesr_regs.sv
// Lane 3 error counter and low/high-speed status registers
`timescale 1ns/1ps
`include "lesr_consts.svh"
module lesr_regs #(
  parameter int CNT_W = `LESR_CNT_W,
  parameter logic [4:0] PORT_ADDR = 5'h00
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // Management pins
  input wire logic mdcPin,
  input wire logic mdioIn,
  output logic mdioOut,
  output logic mdioOutEnN,
  // Configuration held elsewhere
  input wire lesr_pkg::lesr_mode_t mode,
  input wire logic lsTestVerify,
  input wire logic [1:0] lsPatternSel,
  input wire logic [1:0] low_side_lane_select,
  // Lane events and state
  input wire lesr_pkg::lesr_evt_t evt,
  input wire lesr_pkg::lesr_sync_t sync,
  input wire logic [3:0] losAsync
);

  lesr_pkg::lesr_rdreq_t rdReq;
  logic [15:0] rdData_r, rdData_nxt;
  logic [CNT_W-1:0] lane3_code_error_count_r, lane3_code_error_count_nxt;
  logic decFlag_r, decFlag_nxt, losFlag_r, losFlag_nxt;
  logic fifoFlag_r, fifoFlag_nxt, syncFlag_r, syncFlag_nxt;
  logic [3:0] losS1_r, losS1_nxt, losS2_r, losS2_nxt;
  logic rdCnt, rdLs, rdHs, cntEvt;
  logic [3:0] decSrc;
  logic [CNT_W-1:0] cntBase;
  logic [6:0] hsView;

  ////////////////////////////////////////////////////////////////////////////
  // Management port
  lesr_mdio_slave #(.PORT_ADDR(PORT_ADDR)) u_mdio (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .mdcPin(mdcPin),
    .mdioIn(mdioIn),
    .mdioOut(mdioOut),
    .mdioOutEnN(mdioOutEnN),
    .rdReq(rdReq),
    .rdData(rdData_r)
  );

  assign rdCnt = rdReq.valid && rdReq.addr == `LESR_ADDR_CNT;
  assign rdLs = rdReq.valid && rdReq.addr == `LESR_ADDR_LS;
  assign rdHs = rdReq.valid && rdReq.addr == `LESR_ADDR_HS;

  ////////////////////////////////////////////////////////////////////////////
  // Lane 3 error counter; saturates rather than wrapping so a burst never reads small
  always_comb begin
    cntEvt = 1'b0;
    if (lsTestVerify) begin
      cntEvt = evt.patErr[lsPatternSel];
    end else begin
      unique case (mode)
        lesr_pkg::LESR_MODE_10GKR, lesr_pkg::LESR_MODE_1GKX: begin
          cntEvt = evt.decErr[`LESR_LANE3];
        end
        lesr_pkg::LESR_MODE_10G: begin
          cntEvt = evt.slaveDecErr[`LESR_LANE3];
        end
        default: cntEvt = 1'b0;
      endcase
    end
    // Clear on read; an error in the read cycle still counts
    cntBase = rdCnt ? '0 : lane3_code_error_count_r;
    lane3_code_error_count_nxt = cntBase;
    if (cntEvt && cntBase != '1) begin
      lane3_code_error_count_nxt = cntBase + 1'b1;
    end
  end

  // Counter register
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      lane3_code_error_count_r <= CNT_W'(`LESR_CNT_RST);
    end else begin
      lane3_code_error_count_r <= lane3_code_error_count_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Latched status flags; the live set wins over the release on read
  always_comb begin
    losS1_nxt = losAsync;
    losS2_nxt = losS1_r;
    decSrc = (mode == lesr_pkg::LESR_MODE_10G) ? evt.slaveDecErr : evt.decErr;
    decFlag_nxt = decSrc[low_side_lane_select] | (decFlag_r & ~rdLs);
    losFlag_nxt = losS2_r[low_side_lane_select] | (losFlag_r & ~rdLs);
    fifoFlag_nxt = evt.alignFifoErr | (fifoFlag_r & ~rdLs);
    // Latched low: a loss of sync holds zero until read
    syncFlag_nxt = sync.chanSync[low_side_lane_select] & (syncFlag_r | rdLs);
  end

  // Flag registers, clear after reset
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      {decFlag_r, losFlag_r, fifoFlag_r, syncFlag_r} <= 4'h0;
      losS1_r <= 4'h0;
      losS2_r <= 4'h0;
    end else begin
      {decFlag_r, losFlag_r, fifoFlag_r, syncFlag_r} <=
        {decFlag_nxt, losFlag_nxt, fifoFlag_nxt, syncFlag_nxt};
      losS1_r <= losS1_nxt;
      losS2_r <= losS2_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data snapshot; unmapped addresses read zero
  always_comb begin
    hsView = (mode == lesr_pkg::LESR_MODE_10GKR) ? sync.hsSyncRot :
      {sync.hsSyncState, sync.hsSyncRot4};
    rdData_nxt = rdData_r;
    if (rdReq.valid) begin
      rdData_nxt = `LESR_STAT_RST;
      if (rdCnt) begin
        rdData_nxt = 16'(lane3_code_error_count_r);
      end
      if (rdLs) begin
        rdData_nxt[`LESR_LS_DEC_BIT] = decFlag_r;
        rdData_nxt[`LESR_LOW_SIDE_SIGNAL_LOSS_FLAG_BIT] = losFlag_r;
        rdData_nxt[`LESR_LS_FIFO_BIT] = fifoFlag_r;
        rdData_nxt[`LESR_LS_SYNC_BIT] = syncFlag_r;
        rdData_nxt[3:0] = sync.lsSyncPtr;
      end
      if (rdHs) begin
        rdData_nxt[6:0] = hsView;
      end
    end
  end

  // Read data register
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      rdData_r <= `LESR_STAT_RST;
    end else begin
      rdData_r <= rdData_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  sequence s_ls_read;
    rdLs ##1 1'b1;
  endsequence

  property p_cnt_func;
    !lsTestVerify && mode != lesr_pkg::LESR_MODE_10G && evt.decErr[3] && !rdCnt
      && lane3_code_error_count_r != '1
      |=> lane3_code_error_count_r == $past(lane3_code_error_count_r) + 1'b1;
  endproperty
  a_cnt_func: assert property (p_cnt_func) else $error("counter missed decode error");

  property p_cnt_10g;
    !lsTestVerify && mode == lesr_pkg::LESR_MODE_10G && !evt.slaveDecErr[3] && !rdCnt
      |=> lane3_code_error_count_r == $past(lane3_code_error_count_r);
  endproperty
  a_cnt_10g: assert property (p_cnt_10g) else $error("counter moved without slave error");

  property p_cnt_pat;
    lsTestVerify && evt.patErr[lsPatternSel] && rdCnt |=> lane3_code_error_count_r == 1;
  endproperty
  a_cnt_pat: assert property (p_cnt_pat) else $error("pattern error lost on read");

  property p_cor;
    rdCnt && !cntEvt |=> lane3_code_error_count_r == 0
      && rdData_r == 16'($past(lane3_code_error_count_r));
  endproperty
  a_cor: assert property (p_cor) else $error("counter read not cleared");

  property p_cnt_rst;
    $fell(sys_rst) |-> lane3_code_error_count_r == CNT_W'(`LESR_CNT_RST);
  endproperty
  a_cnt_rst: assert property (p_cnt_rst) else $error("counter reset value wrong");

  property p_dec;
    decSrc[low_side_lane_select] |=> decFlag_r [*2] or (decFlag_r ##1 $past(rdLs));
  endproperty
  a_dec: assert property (p_dec) else $error("decode flag not latched");

  property p_los;
    losS2_r[low_side_lane_select] |=> losFlag_r;
  endproperty
  a_los: assert property (p_los) else $error("loss flag not latched");

  property p_fifo;
    evt.alignFifoErr |=> fifoFlag_r;
  endproperty
  a_fifo: assert property (p_fifo) else $error("fifo flag not latched");

  property p_sync_ll;
    !sync.chanSync[low_side_lane_select] ##1 !rdLs |-> !syncFlag_r ##1 !syncFlag_r;
  endproperty
  a_sync_ll: assert property (p_sync_ll) else $error("sync loss not held");

  property p_ptr;
    s_ls_read |-> rdData_r[3:0] == $past(sync.lsSyncPtr) && rdData_r[7:4] == 4'h0;
  endproperty
  a_ptr: assert property (p_ptr) else $error("sync pointer read wrong");

  property p_hs_kr;
    rdHs && mode == lesr_pkg::LESR_MODE_10GKR |=> rdData_r[6:0] == $past(sync.hsSyncRot);
  endproperty
  a_hs_kr: assert property (p_hs_kr) else $error("rotation read wrong");

  property p_hs_oth;
    rdHs && mode != lesr_pkg::LESR_MODE_10GKR
      |=> rdData_r[6:0] == {$past(sync.hsSyncState), $past(sync.hsSyncRot4)};
  endproperty
  a_hs_oth: assert property (p_hs_oth) else $error("sync state read wrong");

  property p_hs_rsv;
    rdHs |=> rdData_r[15:7] == 9'h000;
  endproperty
  a_hs_rsv: assert property (p_hs_rsv) else $error("reserved bits nonzero");

  property p_release;
    decFlag_r && !rdLs && !decSrc[low_side_lane_select] ##1
      rdLs && !decSrc[low_side_lane_select] |=> !decFlag_r;
  endproperty
  a_release: assert property (p_release) else $error("flag not released by read");

endmodule : lesr_regs

// file: rtl/lesr_consts.svh
// Constants for the lane error and status register group
`ifndef LESR_CONSTS_SVH
`define LESR_CONSTS_SVH

// Register map inside the management device
`define LESR_DEVAD 5'h1E
`define LESR_ADDR_CNT 16'h0014
`define LESR_ADDR_LS 16'h0015
`define LESR_ADDR_HS 16'h0016
`define LESR_CNT_W 16
`define LESR_CNT_RST 16'hFFFD
`define LESR_STAT_RST 16'h0000

// Low-speed status field positions
`define LESR_LS_DEC_BIT 11
`define LESR_LOW_SIDE_SIGNAL_LOSS_FLAG_BIT 10
`define LESR_LS_FIFO_BIT 9
`define LESR_LS_SYNC_BIT 8
`define LESR_LANE3 2'h3

// Management frame layout
`define LESR_PREAMBLE 6'h20
`define LESR_HDR_LAST 5'h0C
`define LESR_DATA_LAST 5'h0F
`define LESR_OP_ADDR 2'h0
`define LESR_OP_WRITE 2'h1
`define LESR_OP_RDINC 2'h2
`define LESR_OP_READ 2'h3

`endif

// file: rtl/lesr_pkg.sv
// Types shared by the lane error and status register group
package lesr_pkg;

  // Functional mode of the channel
  typedef enum logic [2:0] {
    LESR_MODE_10GKR = 3'h1,
    LESR_MODE_1GKX = 3'h2,
    LESR_MODE_10G = 3'h4
  } lesr_mode_t;

  // Error events from decoders, pattern checkers and alignment FIFO
  typedef struct packed {
    logic [3:0] decErr;
    logic [3:0] slaveDecErr;
    logic [3:0] patErr;
    logic alignFifoErr;
  } lesr_evt_t;

  // Synchronisation state from the lane aligners
  typedef struct packed {
    logic [3:0] chanSync;
    logic [3:0] lsSyncPtr;
    logic [6:0] hsSyncRot;
    logic [2:0] hsSyncState;
    logic [3:0] hsSyncRot4;
  } lesr_sync_t;

  // Register read request from the management port
  typedef struct packed {
    logic valid;
    logic [15:0] addr;
  } lesr_rdreq_t;

  // Management frame states
  typedef enum logic [4:0] {
    LESR_ST_IDLE = 5'h01,
    LESR_ST_HDR = 5'h02,
    LESR_ST_TA = 5'h04,
    LESR_ST_RD = 5'h08,
    LESR_ST_WR = 5'h10
  } lesr_mdst_t;

endpackage : lesr_pkg

// file: rtl/lesr_mdio_slave.sv
// Management data port slave: frames in, register reads out
`timescale 1ns/1ps
`include "lesr_consts.svh"
module lesr_mdio_slave #(
  parameter logic [4:0] PORT_ADDR = 5'h00
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // Management pins
  input wire logic mdcPin,
  input wire logic mdioIn,
  output logic mdioOut,
  output logic mdioOutEnN,
  // Register side
  output lesr_pkg::lesr_rdreq_t rdReq,
  input wire logic [15:0] rdData
);

  lesr_pkg::lesr_mdst_t st_r, st_nxt;
  logic mdcS1_r, mdcS2_r, mdcS3_r, dS1_r, dS2_r;
  logic mdcS1_nxt, mdcS2_nxt, mdcS3_nxt, dS1_nxt, dS2_nxt;
  logic [5:0] ones_r, ones_nxt;
  logic [4:0] bitCnt_r, bitCnt_nxt;
  logic [15:0] sh_r, sh_nxt, addr_r, addr_nxt;
  logic [1:0] op_r, op_nxt;
  logic out_r, out_nxt, oeN_r, oeN_nxt;
  lesr_pkg::lesr_rdreq_t req_r, req_nxt;
  logic rise;
  logic [12:0] hdr;
  logic isRead;

  assign rise = mdcS2_r & ~mdcS3_r;
  assign hdr = {sh_r[11:0], dS2_r};
  assign isRead = op_r[1];
  assign mdioOut = out_r;
  assign mdioOutEnN = oeN_r;
  assign rdReq = req_r;

  ////////////////////////////////////////////////////////////////////////////
  // Frame engine; pins are sampled on the synchronised rising edge of the clock pin
  always_comb begin
    mdcS1_nxt = mdcPin;
    mdcS2_nxt = mdcS1_r;
    mdcS3_nxt = mdcS2_r;
    dS1_nxt = mdioIn;
    dS2_nxt = dS1_r;
    st_nxt = st_r;
    ones_nxt = ones_r;
    bitCnt_nxt = bitCnt_r;
    sh_nxt = sh_r;
    addr_nxt = addr_r;
    op_nxt = op_r;
    out_nxt = out_r;
    oeN_nxt = oeN_r;
    req_nxt = '{valid: 1'b0, addr: addr_r};
    if (rise) begin
      unique case (st_r)
        lesr_pkg::LESR_ST_IDLE: begin
          if (dS2_r) begin
            ones_nxt = (ones_r == `LESR_PREAMBLE) ? ones_r : ones_r + 6'h01;
          end else begin
            // A zero after a full preamble is the first start bit
            if (ones_r == `LESR_PREAMBLE) begin
              st_nxt = lesr_pkg::LESR_ST_HDR;
            end
            ones_nxt = 6'h00;
            bitCnt_nxt = 5'h00;
          end
        end
        lesr_pkg::LESR_ST_HDR: begin
          sh_nxt = {sh_r[14:0], dS2_r};
          bitCnt_nxt = bitCnt_r + 5'h01;
          // Thirteen header bits follow the first start bit; the last one is index 12
          if (bitCnt_r == `LESR_HDR_LAST) begin
            bitCnt_nxt = 5'h00;
            op_nxt = hdr[11:10];
            if (!hdr[12] && hdr[9:5] == PORT_ADDR && hdr[4:0] == `LESR_DEVAD) begin
              st_nxt = lesr_pkg::LESR_ST_TA;
              req_nxt.valid = hdr[11];
            end else begin
              st_nxt = lesr_pkg::LESR_ST_IDLE;
            end
          end
        end
        lesr_pkg::LESR_ST_TA: begin
          bitCnt_nxt = bitCnt_r + 5'h01;
          if (bitCnt_r == 5'h00) begin
            // Second turnaround bit: drive zero on reads
            out_nxt = 1'b0;
            oeN_nxt = ~isRead;
          end else begin
            bitCnt_nxt = 5'h00;
            sh_nxt = rdData;
            out_nxt = rdData[15];
            st_nxt = isRead ? lesr_pkg::LESR_ST_RD : lesr_pkg::LESR_ST_WR;
          end
        end
        lesr_pkg::LESR_ST_RD: begin
          bitCnt_nxt = bitCnt_r + 5'h01;
          sh_nxt = {sh_r[14:0], 1'b0};
          out_nxt = sh_r[14];
          if (bitCnt_r == `LESR_DATA_LAST) begin
            oeN_nxt = 1'b1;
            out_nxt = 1'b0;
            st_nxt = lesr_pkg::LESR_ST_IDLE;
            if (op_r == `LESR_OP_RDINC) begin
              addr_nxt = addr_r + 16'h0001;
            end
          end
        end
        lesr_pkg::LESR_ST_WR: begin
          bitCnt_nxt = bitCnt_r + 5'h01;
          sh_nxt = {sh_r[14:0], dS2_r};
          if (bitCnt_r == `LESR_DATA_LAST) begin
            // Writes to this group are ignored: every register is read-only
            if (op_r == `LESR_OP_ADDR) begin
              addr_nxt = {sh_r[14:0], dS2_r};
            end
            st_nxt = lesr_pkg::LESR_ST_IDLE;
          end
        end
        default: begin
          st_nxt = lesr_pkg::LESR_ST_IDLE;
          oeN_nxt = 1'b1;
        end
      endcase
    end
  end

  // Register stage of the frame engine
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      st_r <= lesr_pkg::LESR_ST_IDLE;
      {mdcS1_r, mdcS2_r, mdcS3_r, dS1_r, dS2_r} <= 5'h00;
      ones_r <= 6'h00;
      bitCnt_r <= 5'h00;
      sh_r <= 16'h0000;
      addr_r <= 16'h0000;
      op_r <= 2'h0;
      out_r <= 1'b0;
      oeN_r <= 1'b1;
      req_r <= '0;
    end else begin
      st_r <= st_nxt;
      {mdcS1_r, mdcS2_r, mdcS3_r, dS1_r, dS2_r} <=
        {mdcS1_nxt, mdcS2_nxt, mdcS3_nxt, dS1_nxt, dS2_nxt};
      ones_r <= ones_nxt;
      bitCnt_r <= bitCnt_nxt;
      sh_r <= sh_nxt;
      addr_r <= addr_nxt;
      op_r <= op_nxt;
      out_r <= out_nxt;
      oeN_r <= oeN_nxt;
      req_r <= req_nxt;
    end
  end

endmodule : lesr_mdio_slave

// file: bench/lesr_mdio_host.sv
// Management host model that runs clause-45 style frames on the data pin
`timescale 1ns/1ps
module lesr_mdio_host (
  // Clock
  input wire logic sys_clk,
  // Management pins, enable low while the host drives
  output logic mdc,
  output logic hostDrv,
  output logic hostEnN,
  input wire logic mdioWire
);
  // Device address sent in every frame; the bench may aim a frame elsewhere
  logic [4:0] devAddr = 5'h1E;
  ////////////////////////////////////////
  // Idle: clock parked low, data left to the pull-up
  initial begin
    mdc = 1'b0;
    hostDrv = 1'b1;
    hostEnN = 1'b1;
  end

  // Preamble, start, op, port 0, device address, turnaround, data, then one released
  // bit so the device can end its drive before any following preamble
  task automatic frame(input logic [1:0] op, input logic [15:0] wd, output logic [15:0] rd);
    logic [64:0] bits;
    logic rel;
    bits = {32'hFFFFFFFF, 2'h0, op, 5'h00, devAddr, 2'h2, wd, 1'h1};
    rd = 16'h0000;
    for (int i = 64; i >= 0; i--) begin
      // Reads hand the line over from the turnaround on
      rel = (i == 0) || (op[1] && i <= 18);
      @(posedge sys_clk);
      mdc <= 1'b0;
      hostEnN <= rel;
      hostDrv <= rel | bits[i];
      repeat (7) @(posedge sys_clk);
      // Sample just before the rise: the device moves on a few cycles after each
      // rise, so a sample late in the high phase would catch the following bit
      if (op[1] && i >= 1 && i <= 16) rd = {rd[14:0], mdioWire};
      mdc <= 1'b1;
      repeat (8) @(posedge sys_clk);
    end
    @(posedge sys_clk);
    mdc <= 1'b0;
    hostEnN <= 1'b1;
  endtask : frame
endmodule : lesr_mdio_host

// file: bench/testbench.sv
// Self-checking bench for the lane error and status register group
`timescale 1ns/1ps
module testbench;
  typedef struct packed {
    lesr_pkg::lesr_mode_t mode;
    logic tv;
    logic [1:0] sel;
    logic [1:0] ln;
    lesr_pkg::lesr_evt_t ev;
    logic los;
    logic [15:0] cnt;
    logic [15:0] ls;
    logic [15:0] hs;
  } lesr_row_t;
  localparam lesr_pkg::lesr_mode_t KR = lesr_pkg::LESR_MODE_10GKR;
  localparam lesr_pkg::lesr_mode_t KX = lesr_pkg::LESR_MODE_1GKX;
  localparam lesr_pkg::lesr_mode_t XG = lesr_pkg::LESR_MODE_10G;
  ////////////////////////////////////////
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic mdc;
  logic hostDrv;
  logic hostEnN;
  logic mdioOut;
  logic mdioOutEnN;
  logic mdioWire;
  lesr_pkg::lesr_mode_t mode = KR;
  logic lsTestVerify = 1'b0;
  logic [1:0] lsPatternSel = 2'h0;
  logic [1:0] laneSel = 2'h3;
  lesr_pkg::lesr_evt_t evt = '0;
  lesr_pkg::lesr_sync_t sync = {4'hF, 18'h0};
  logic [3:0] losAsync = 4'h0;
  int fails = 0;
  int comparisons = 0;
  // Each row: 3 event pulses, then the counter, low and high status words
  lesr_row_t rows [10] = '{
    '{KR, 1'b0, 2'h0, 2'h3, 13'h1000, 1'b0, 16'h0003, 16'h0909, 16'h005A},
    '{KX, 1'b0, 2'h0, 2'h3, 13'h1001, 1'b1, 16'h0003, 16'h0F09, 16'h005C},
    '{XG, 1'b0, 2'h0, 2'h3, 13'h1100, 1'b0, 16'h0003, 16'h0909, 16'h005C},
    '{XG, 1'b0, 2'h0, 2'h3, 13'h1000, 1'b0, 16'h0000, 16'h0109, 16'h005C},
    '{KR, 1'b0, 2'h0, 2'h2, 13'h1000, 1'b1, 16'h0003, 16'h0109, 16'h005A},
    '{KR, 1'b1, 2'h0, 2'h3, 13'h0002, 1'b0, 16'h0003, 16'h0109, 16'h005A},
    '{KX, 1'b1, 2'h1, 2'h3, 13'h0004, 1'b0, 16'h0003, 16'h0109, 16'h005C},
    '{XG, 1'b1, 2'h2, 2'h3, 13'h0008, 1'b0, 16'h0003, 16'h0109, 16'h005C},
    '{KR, 1'b1, 2'h3, 2'h3, 13'h0010, 1'b0, 16'h0003, 16'h0109, 16'h005A},
    '{KR, 1'b1, 2'h1, 2'h3, 13'h0002, 1'b0, 16'h0000, 16'h0109, 16'h005A}
  };

  // 25 MHz clock
  always #20 sys_clk = ~sys_clk;

  // Data line with its pull-up: whoever enables drives, else it floats high
  assign mdioWire = !mdioOutEnN ? mdioOut : (!hostEnN ? hostDrv : 1'b1);

  ////////////////////////////////////////
  // Device under test and the host on its management pins
  lesr_regs dut (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .mdcPin(mdc), .mdioIn(mdioWire),
    .mdioOut(mdioOut), .mdioOutEnN(mdioOutEnN), .mode(mode),
    .lsTestVerify(lsTestVerify), .lsPatternSel(lsPatternSel),
    .low_side_lane_select(laneSel), .evt(evt), .sync(sync), .losAsync(losAsync)
  );
  lesr_mdio_host host (
    .sys_clk(sys_clk), .mdc(mdc), .hostDrv(hostDrv), .hostEnN(hostEnN),
    .mdioWire(mdioWire)
  );

  ////////////////////////////////////////
  // Compare one word and count it
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: read %h, wanted %h", $time, seen, exp);
    end
  endtask : check

  // Address frame then plain read frame
  task automatic rd(input logic [15:0] a, output logic [15:0] d);
    host.frame(2'h0, a, d);
    host.frame(2'h3, 16'h0000, d);
  endtask : rd

  // Three one-cycle events, loss of signal on lane 3 held across them
  task automatic pulse(input lesr_pkg::lesr_evt_t e, input logic l);
    for (int i = 0; i < 3; i++) begin
      @(posedge sys_clk);
      evt <= e;
      losAsync <= {l, 3'h0};
      @(posedge sys_clk);
      evt <= '0;
    end
    @(posedge sys_clk);
    losAsync <= 4'h0;
    repeat (4) @(posedge sys_clk);
  endtask : pulse

  // Verdict and end of run
  task automatic conclude;
    $display("comparisons %0d, fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : conclude

  // Watchdog sized well above the roughly 67k cycles the tests take
  initial begin
    repeat (90000) @(posedge sys_clk);
    fails++;
    $display("unexpected at %0t: run did not finish", $time);
    conclude();
  end

  ////////////////////////////////////////
  // Main sequence
  initial begin
    logic [15:0] d;
    repeat (12) @(posedge sys_clk);
    sys_rst <= 1'b0;
    repeat (2) @(posedge sys_clk);
    // A write is dropped; the reset value holds until the first read clears it
    host.frame(2'h0, 16'h0014, d);
    host.frame(2'h1, 16'h0000, d);
    host.frame(2'h2, 16'h0000, d);
    check(d, 16'hFFFD);
    host.frame(2'h0, 16'h0014, d);
    host.frame(2'h2, 16'h0000, d);
    check(d, 16'h0000);
    host.frame(2'h2, 16'h0000, d);
    check(d, 16'h0000);
    host.frame(2'h3, 16'h0000, d);
    check(d, 16'h0000);
    rd(16'h0020, d);
    check(d, 16'h0000);
    @(posedge sys_clk);
    sync <= {4'hF, 4'h9, 7'h5A, 3'h5, 4'hC};
    rd(16'h0015, d);
    check(d, 16'h0109);
    // A frame for another device is ignored: the address stays on the low status word
    host.devAddr = 5'h1D;
    host.frame(2'h0, 16'h0016, d);
    host.devAddr = 5'h1E;
    host.frame(2'h3, 16'h0000, d);
    check(d, 16'h0109);
    $display("test reset values done");
    // Table of modes, lanes and pattern selects
    foreach (rows[i]) begin
      @(posedge sys_clk);
      mode <= rows[i].mode;
      lsTestVerify <= rows[i].tv;
      lsPatternSel <= rows[i].sel;
      laneSel <= rows[i].ln;
      pulse(rows[i].ev, rows[i].los);
      host.frame(2'h0, 16'h0014, d);
      host.frame(2'h2, 16'h0000, d);
      check(d, rows[i].cnt);
      host.frame(2'h2, 16'h0000, d);
      check(d, rows[i].ls);
      host.frame(2'h3, 16'h0000, d);
      check(d, rows[i].hs);
      $display("test row %0d done", i);
    end
    // Flags hold until read; a condition still present re-latches
    @(posedge sys_clk);
    lsTestVerify <= 1'b0;
    evt <= 13'h0001;
    losAsync <= 4'h8;
    sync.chanSync <= 4'h0;
    @(posedge sys_clk);
    evt <= '0;
    repeat (4) @(posedge sys_clk);
    sync.chanSync <= 4'hF;
    rd(16'h0015, d);
    check(d, 16'h0609);
    losAsync <= 4'h0;
    rd(16'h0015, d);
    check(d, 16'h0509);
    $display("test latch hold done");
    // A held pattern error counts every cycle; the one in the read cycle survives
    // the clear, so two reads one frame apart see exactly one frame of cycles
    @(posedge sys_clk);
    lsTestVerify <= 1'b1;
    lsPatternSel <= 2'h0;
    evt <= 13'h0002;
    rd(16'h0014, d);
    host.frame(2'h3, 16'h0000, d);
    check(d, 16'h0411);
    evt <= '0;
    lsTestVerify <= 1'b0;
    $display("test held error done");
    // Reset in mid-run brings the counter and flags back to their defaults
    pulse(13'h1000, 1'b1);
    sys_rst <= 1'b1;
    repeat (12) @(posedge sys_clk);
    sys_rst <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rd(16'h0014, d);
    check(d, 16'hFFFD);
    rd(16'h0015, d);
    check(d, 16'h0009);
    $display("test second reset done");
    conclude();
  end
endmodule : testbench
